// file: shared/vpa_pkg.sv
// Constants and types shared by the virtual PHY auto-negotiation register block
package vpa_pkg;

  // ----------------------------------------------------------------
  // Register placement
  // ----------------------------------------------------------------
  localparam logic [8:0] VPA_ADV_OFS = 9'h1d0;
  localparam logic [8:0] VPA_LP_OFS = 9'h1d4;
  localparam logic [4:0] VPA_ADV_IDX = 5'h04;
  localparam logic [4:0] VPA_LP_IDX = 5'h05;

  // ----------------------------------------------------------------
  // Field positions within the 16-bit register image
  // ----------------------------------------------------------------
  localparam int VPA_B_NP = 15;
  localparam int VPA_B_ACK = 14;
  localparam int VPA_B_RF = 13;
  localparam int VPA_B_ASYM = 11;
  localparam int VPA_B_SYM = 10;
  localparam int VPA_B_T4 = 9;
  localparam int VPA_ABIL_HI = 8;
  localparam int VPA_ABIL_LO = 5;
  localparam int VPA_SEL_HI = 4;
  localparam int VPA_SEL_LO = 0;

  // ----------------------------------------------------------------
  // Values after reset and fixed codes
  // ----------------------------------------------------------------
  localparam logic [4:0] VPA_SEL_IEEE = 5'h01;
  localparam logic [3:0] VPA_ABIL_RST = 4'hf;
  localparam logic [1:0] VPA_PAUSE_RST = 2'h0;
  localparam logic [15:0] VPA_WORD_RST = 16'h0000;
  localparam logic [31:0] VPA_CSR_RST = 32'h0000_0000;
  localparam logic [15:0] VPA_UPPER_ZERO = 16'h0000;
  localparam logic [3:0] VPA_LP_10F = 4'h2;
  localparam logic [3:0] VPA_LP_100F = 4'h8;
  localparam logic [3:0] VPA_LP_10H = 4'h1;
  localparam logic [3:0] VPA_LP_100H = 4'h4;

  // ----------------------------------------------------------------
  // Strap and pin positions in the synchronised pin vector
  // ----------------------------------------------------------------
  localparam int VPA_NPINS = 5;
  localparam int VPA_P_MANFC = 0;
  localparam int VPA_P_DFC = 1;
  localparam int VPA_P_DPOL = 2;
  localparam int VPA_P_SPEED = 3;
  localparam int VPA_P_PDUP = 4;
  localparam logic [VPA_NPINS-1:0] VPA_PINS_RST = 5'h00;

  // Start-up sequence: two cycles for the pin synchronisers, then latch
  typedef enum logic [1:0] {
    VPA_WAIT1 = 2'h0,
    VPA_WAIT2 = 2'h1,
    VPA_LATCH = 2'h3,
    VPA_RUN = 2'h2
  } vpa_boot_t;

endpackage

// file: hw/vpa_pin_sync.sv
// Two-stage synchroniser for the strap and duplex pins
`timescale 1ns/1ps
module vpa_pin_sync
  import vpa_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [VPA_NPINS-1:0] pins,
  output logic [VPA_NPINS-1:0] pins_sync
);

  typedef struct packed {
    logic [VPA_NPINS-1:0] s1;
    logic [VPA_NPINS-1:0] s2;
  } vpa_sync_st_t;

  vpa_sync_st_t st_r;
  vpa_sync_st_t st_nxt;

  // ----------------------------------------------------------------
  // Next state: first stage feeds only the second stage
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < VPA_NPINS; i++) begin
      st_nxt.s1[i] = pins[i];
      st_nxt.s2[i] = st_r.s1[i];
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= {VPA_PINS_RST, VPA_PINS_RST};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign pins_sync = st_r.s2;

endmodule

// file: hw/vpa_pause_res.sv
// Emulated partner pause resolution, frozen at auto-negotiation completion
`timescale 1ns/1ps
module vpa_pause_res
  import vpa_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic an_done,
  input wire logic adv_asym,
  input wire logic adv_sym,
  input wire logic dfc_strap,
  output logic lp_asym,
  output logic lp_sym
);

  typedef struct packed {
    logic [1:0] pause;
  } vpa_pres_st_t;

  vpa_pres_st_t st_r;
  vpa_pres_st_t st_nxt;
  logic [1:0] res;

  // ----------------------------------------------------------------
  // Partner always grants the local request; both-advertised uses strap
  // ----------------------------------------------------------------
  always_comb begin
    case ({adv_asym, adv_sym}) // RULE18
      2'h0: res = 2'h0;
      2'h1: res = 2'h1;
      2'h2: res = 2'h3;
      2'h3: res = dfc_strap ? 2'h3 : 2'h2;
      default: res = 2'h0;
    endcase
  end

  // Snapshot only when negotiation completes; later edits wait for a rerun
  always_comb begin
    st_nxt = st_r;
    if (an_done) begin
      st_nxt.pause = res; // RULE19
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= VPA_PAUSE_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign lp_asym = st_r.pause[1];
  assign lp_sym = st_r.pause[0];

endmodule

// file: hw/vpa_regs.sv
// Virtual PHY advertisement and emulated partner ability registers
// What this block does
// [RULE1] Advertisement next-page bit 15 is read-only and always reads zero.
// [RULE2] Advertisement remote-fault bit 13 is read-only, resets zero, does nothing.
// [RULE3] Advertised pause bits 11 and 10 writable; default set unless manual strap high.
// [RULE4] Straps are captured when reset is released and held afterwards.
// [RULE5] Advertisement bit 9 for 100BASE-T4 is read-only and reads zero.
// [RULE6] Advertised ability bits 8 to 5 are writable and reset to one.
// [RULE7] Advertisement selector bits 4:0 writable, reset 00001b; software writes only that.
// [RULE8] Configuration loader may overwrite the whole advertisement register; here it sets only bits 11, 10 and 8:0.
// [RULE9] Registers are 32-bit words with zero upper half; 16 bits over MII.
// [RULE10] Partner ability register is read-only and generated inside the block.
// [RULE11] Partner next-page bit 15 always reads zero.
// [RULE12] Partner acknowledge bit 14 always reads one.
// [RULE13] Partner remote-fault bit 13 always reads zero.
// [RULE14] Partner 100BASE-T4 bit 9 always reads zero.
// [RULE15] Partner bits 11 and 10 report emulated asymmetric and symmetric pause.
// [RULE16] Partner bits 8 to 5 report emulated speed and duplex abilities.
// [RULE17] Partner selector bits 4:0 are read-only and read 00001b.
// [RULE18] Partner pause follows the local advertisement, strap breaks the both case.
// [RULE19] Partner pause is frozen at negotiation completion until the next run.
// [RULE20] Partner bits 8 to 5 give full duplex when pin matches polarity strap.
// [RULE21] Reserved bits 14, 12 and 31-16 read zero and ignore writes.
`timescale 1ns/1ps
module vpa_regs
  import vpa_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CSR_RE,
  input wire logic CSR_WE,
  input wire logic [8:0] CSR_ADDR,
  input wire logic [31:0] CSR_WDATA,
  output logic [31:0] CSR_RDATA,
  input wire logic MIIM_RE,
  input wire logic MIIM_WE,
  input wire logic [4:0] MIIM_IDX,
  input wire logic [15:0] MIIM_WDATA,
  output logic [15:0] MIIM_RDATA,
  input wire logic LOAD_WE,
  input wire logic [15:0] LOAD_DATA,
  input wire logic AN_DONE,
  input wire logic MANUAL_FLOW_CTRL_CFG_PIN,
  input wire logic DUPLEX_FLOW_CTRL_CFG_PIN,
  input wire logic DUPLEX_POL_CFG_PIN,
  input wire logic SPEED_CFG_PIN,
  input wire logic PORT_ZERO_DUPLEX_PIN,
  output logic [15:0] ADV_WORD,
  output logic [15:0] LP_WORD,
  output logic STRAPS_VALID
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    vpa_boot_t boot;
    logic valid;
    logic man_fc;
    logic dfc;
    logic dpol;
    logic speed;
    logic [1:0] pause;
    logic [3:0] abil;
    logic [4:0] sel;
    logic [3:0] lp_abil;
    logic [31:0] csr_rdata;
    logic [15:0] miim_rdata;
  } vpa_top_st_t;

  localparam vpa_top_st_t VPA_TOP_RST = '{
    boot: VPA_WAIT1,
    valid: 1'b0,
    man_fc: 1'b0,
    dfc: 1'b0,
    dpol: 1'b0,
    speed: 1'b0,
    pause: VPA_PAUSE_RST,
    abil: VPA_ABIL_RST,
    sel: VPA_SEL_IEEE,
    lp_abil: VPA_LP_10H,
    csr_rdata: VPA_CSR_RST,
    miim_rdata: VPA_WORD_RST
  };

  vpa_top_st_t st_r;
  vpa_top_st_t st_nxt;
  logic [VPA_NPINS-1:0] pins;
  logic [VPA_NPINS-1:0] pins_s;
  logic lp_asym;
  logic lp_sym;
  logic [15:0] adv_w;
  logic [15:0] lp_w;
  logic host_wr;
  logic [15:0] host_data;
  logic [15:0] wr_data;
  logic adv_wr;
  logic full_dup;

  // ----------------------------------------------------------------
  // Read decode shared by the word port and the MII port
  // ----------------------------------------------------------------
  function automatic logic [15:0] vpa_rd_word(
    input logic hit_adv,
    input logic hit_lp,
    input logic [15:0] adv,
    input logic [15:0] lp
  );
    vpa_rd_word = hit_adv ? adv : (hit_lp ? lp : VPA_WORD_RST);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and pause resolution
  // ----------------------------------------------------------------
  assign pins = {PORT_ZERO_DUPLEX_PIN, SPEED_CFG_PIN, DUPLEX_POL_CFG_PIN,
                 DUPLEX_FLOW_CTRL_CFG_PIN, MANUAL_FLOW_CTRL_CFG_PIN};

  vpa_pin_sync u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .pins(pins),
    .pins_sync(pins_s)
  );

  vpa_pause_res u_pause (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .an_done(AN_DONE), // RULE19
    .adv_asym(st_r.pause[1]),
    .adv_sym(st_r.pause[0]),
    .dfc_strap(st_r.dfc),
    .lp_asym(lp_asym),
    .lp_sym(lp_sym)
  );

  // ----------------------------------------------------------------
  // Register images; fixed and reserved bits are constants
  // ----------------------------------------------------------------
  always_comb begin
    adv_w = VPA_WORD_RST; // RULE21
    adv_w[VPA_B_NP] = 1'b0; // RULE1
    adv_w[VPA_B_RF] = 1'b0; // RULE2
    adv_w[VPA_B_ASYM] = st_r.pause[1];
    adv_w[VPA_B_SYM] = st_r.pause[0];
    adv_w[VPA_B_T4] = 1'b0; // RULE5
    adv_w[VPA_ABIL_HI:VPA_ABIL_LO] = st_r.abil;
    adv_w[VPA_SEL_HI:VPA_SEL_LO] = st_r.sel;
  end

  // Emulated partner word, built only from internal state
  always_comb begin
    lp_w = VPA_WORD_RST; // RULE10
    lp_w[VPA_B_NP] = 1'b0; // RULE11
    lp_w[VPA_B_ACK] = 1'b1; // RULE12
    lp_w[VPA_B_RF] = 1'b0; // RULE13
    lp_w[VPA_B_ASYM] = lp_asym; // RULE15
    lp_w[VPA_B_SYM] = lp_sym; // RULE15
    lp_w[VPA_B_T4] = 1'b0; // RULE14
    lp_w[VPA_ABIL_HI:VPA_ABIL_LO] = st_r.lp_abil; // RULE16
    lp_w[VPA_SEL_HI:VPA_SEL_LO] = VPA_SEL_IEEE; // RULE17
  end

  // ----------------------------------------------------------------
  // Write selection: loader beats host, word port beats MII port
  // ----------------------------------------------------------------
  always_comb begin
    host_wr = 1'b0;
    host_data = CSR_WDATA[15:0]; // RULE9
    if (CSR_WE && (CSR_ADDR == VPA_ADV_OFS)) begin
      host_wr = 1'b1;
    end else if (MIIM_WE && (MIIM_IDX == VPA_ADV_IDX)) begin
      host_wr = 1'b1;
      host_data = MIIM_WDATA;
    end
    adv_wr = LOAD_WE || host_wr; // RULE8
    wr_data = LOAD_WE ? LOAD_DATA : host_data;
  end

  // Full duplex when the port pin equals the polarity strap
  assign full_dup = (pins_s[VPA_P_PDUP] == st_r.dpol); // RULE20

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Start-up walk; straps latched once synchronisers hold real levels
    case (st_r.boot)
      VPA_WAIT1: st_nxt.boot = VPA_WAIT2;
      VPA_WAIT2: st_nxt.boot = VPA_LATCH;
      VPA_LATCH: begin
        st_nxt.boot = VPA_RUN;
        st_nxt.valid = 1'b1; // RULE4
        st_nxt.man_fc = pins_s[VPA_P_MANFC]; // RULE4
        st_nxt.dfc = pins_s[VPA_P_DFC]; // RULE4
        st_nxt.dpol = pins_s[VPA_P_DPOL]; // RULE4
        st_nxt.speed = pins_s[VPA_P_SPEED]; // RULE4
        st_nxt.pause = pins_s[VPA_P_MANFC] ? 2'h0 : 2'h3; // RULE3
      end
      VPA_RUN: st_nxt.boot = VPA_RUN;
      default: begin
        // Illegal code: restart the walk and drop the valid flag
        st_nxt.boot = VPA_WAIT1;
        st_nxt.valid = 1'b0;
      end
    endcase
    // Only writable fields take write data; bits 15, 13, 9 are dropped
    if (adv_wr) begin
      st_nxt.pause = {wr_data[VPA_B_ASYM], wr_data[VPA_B_SYM]}; // RULE3
      st_nxt.abil = wr_data[VPA_ABIL_HI:VPA_ABIL_LO]; // RULE6
      st_nxt.sel = wr_data[VPA_SEL_HI:VPA_SEL_LO]; // RULE7
    end
    // Partner speed follows the latched speed strap, duplex follows the duplex pin
    if (st_r.speed) begin
      st_nxt.lp_abil = full_dup ? VPA_LP_100F : VPA_LP_100H; // RULE20
    end else begin
      st_nxt.lp_abil = full_dup ? VPA_LP_10F : VPA_LP_10H; // RULE20
    end
    // Read data: upper half always zero on the word port
    if (CSR_RE) begin
      st_nxt.csr_rdata = {VPA_UPPER_ZERO, vpa_rd_word(CSR_ADDR == VPA_ADV_OFS,
                          CSR_ADDR == VPA_LP_OFS, adv_w, lp_w)}; // RULE9
    end
    if (MIIM_RE) begin
      st_nxt.miim_rdata = vpa_rd_word(MIIM_IDX == VPA_ADV_IDX,
                                      MIIM_IDX == VPA_LP_IDX, adv_w, lp_w); // RULE9
    end
  end

  // State register; clock enable freezes everything but reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_r <= VPA_TOP_RST;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign CSR_RDATA = st_r.csr_rdata;
  assign MIIM_RDATA = st_r.miim_rdata;
  assign ADV_WORD = adv_w;
  assign LP_WORD = lp_w;
  assign STRAPS_VALID = st_r.valid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  property p_adv_np_zero;
    ADV_WORD[VPA_B_NP] == 1'b0 && ADV_WORD[VPA_B_T4] == 1'b0;
  endproperty
  a_adv_np_zero: assert property (p_adv_np_zero) // RULE1
    else $error("advertised next page or T4 set");

  property p_adv_rf_zero;
    CE && CSR_WE && CSR_ADDR == VPA_ADV_OFS && !LOAD_WE && CSR_WDATA[VPA_B_RF]
      |=> ADV_WORD[VPA_B_RF] == 1'b0;
  endproperty
  a_adv_rf_zero: assert property (p_adv_rf_zero) // RULE2
    else $error("advertised remote fault took a write");

  property p_strap_pause;
    CE && st_r.boot == VPA_LATCH && !adv_wr
      |=> ADV_WORD[VPA_B_ASYM:VPA_B_SYM] == {2{~$past(pins_s[VPA_P_MANFC])}};
  endproperty
  a_strap_pause: assert property (p_strap_pause) // RULE3
    else $error("pause default does not follow manual strap");

  property p_strap_hold;
    STRAPS_VALID |=> $stable(st_r.dfc) && $stable(st_r.dpol) && $stable(st_r.speed)
      && $stable(st_r.man_fc);
  endproperty
  a_strap_hold: assert property (p_strap_hold) // RULE4
    else $error("latched strap changed while out of reset");

  property p_host_write;
    CE && MIIM_WE && MIIM_IDX == VPA_ADV_IDX && !LOAD_WE && !CSR_WE
      |=> ADV_WORD[VPA_ABIL_HI:VPA_SEL_LO] == $past(MIIM_WDATA[VPA_ABIL_HI:VPA_SEL_LO]);
  endproperty
  a_host_write: assert property (p_host_write) // RULE6
    else $error("ability or selector write lost");

  property p_loader_write;
    CE && LOAD_WE |=> ADV_WORD == ($past(LOAD_DATA) & 16'h0dff);
  endproperty
  a_loader_write: assert property (p_loader_write) // RULE8
    else $error("loader write not applied");

  property p_csr_upper;
    CE && CSR_RE |=> CSR_RDATA[31:16] == VPA_UPPER_ZERO
      && CSR_RDATA[15:0] == vpa_rd_word($past(CSR_ADDR) == VPA_ADV_OFS,
                                        $past(CSR_ADDR) == VPA_LP_OFS,
                                        $past(adv_w), $past(lp_w));
  endproperty
  a_csr_upper: assert property (p_csr_upper) // RULE9
    else $error("word read data wrong");

  property p_lp_fixed;
    LP_WORD[15:12] == 4'h4 && LP_WORD[VPA_B_T4] == 1'b0
      && LP_WORD[VPA_SEL_HI:VPA_SEL_LO] == VPA_SEL_IEEE;
  endproperty
  a_lp_fixed: assert property (p_lp_fixed) // RULE12
    else $error("partner fixed bits wrong");

  property p_lp_freeze;
    !(CE && AN_DONE) |=> $stable(LP_WORD[VPA_B_ASYM:VPA_B_SYM]);
  endproperty
  a_lp_freeze: assert property (p_lp_freeze) // RULE19
    else $error("partner pause moved without negotiation");

  property p_lp_both;
    CE && AN_DONE && ADV_WORD[VPA_B_ASYM:VPA_B_SYM] == 2'h3
      |=> LP_WORD[VPA_B_ASYM:VPA_B_SYM] == ($past(st_r.dfc) ? 2'h3 : 2'h2);
  endproperty
  a_lp_both: assert property (p_lp_both) // RULE18
    else $error("partner pause resolution wrong");

  property p_lp_dup;
    CE && st_r.speed && full_dup |=> LP_WORD[VPA_ABIL_HI:VPA_ABIL_LO] == VPA_LP_100F;
  endproperty
  a_lp_dup: assert property (p_lp_dup) // RULE20
    else $error("partner duplex code wrong");

  c_straps_latched: cover property (st_r.boot == VPA_LATCH ##1 STRAPS_VALID);
  c_an_done: cover property (CE && AN_DONE ##1 LP_WORD[VPA_B_SYM]);
  c_loader: cover property (CE && LOAD_WE && CSR_WE);
  c_miim_read: cover property (CE && MIIM_RE && MIIM_IDX == VPA_LP_IDX);

endmodule

// file: dv/vpa_host_model.sv
// Host management controller model issuing MII register accesses
`timescale 1ns/1ps
module vpa_host_model
  import vpa_pkg::*;
(
  input wire logic clk,
  output logic re,
  output logic we,
  output logic [4:0] idx,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  // Not a request, so the bus carries a pattern rather than zeros
  initial begin
    re = 1'b0;
    we = 1'b0;
    idx = 5'h1f;
    wdata = 16'h5a5a;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Write one 16-bit register; the advertisement selector always carries the IEEE code
  task automatic mii_wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    idx <= i;
    wdata <= (i == VPA_ADV_IDX) ? {d[15:5], VPA_SEL_IEEE} : d;
    @(posedge clk);
    we <= 1'b0;
    idx <= ~i;
    wdata <= ~d; // Released bus shows the inverse
  endtask

  // Read one 16-bit register; data is taken once the answer edge has landed
  task automatic mii_rd(input logic [4:0] i, output logic [15:0] d);
    @(posedge clk);
    re <= 1'b1;
    idx <= i;
    @(posedge clk);
    re <= 1'b0;
    idx <= ~i;
    #1;
    d = rdata;
  endtask
endmodule

// file: dv/tb_virtual_phy_autoneg_regs.sv
// Self-checking testbench for the virtual PHY advertisement and partner registers
`timescale 1ns/1ps
module tb_virtual_phy_autoneg_regs;
  import vpa_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic csr_re = 1'b0;
  logic csr_we = 1'b0;
  logic [8:0] csr_addr = 9'h000;
  logic [31:0] csr_wdata = 32'h0;
  logic [31:0] csr_rdata;
  logic miim_re;
  logic miim_we;
  logic [4:0] miim_idx;
  logic [15:0] miim_wdata;
  logic [15:0] miim_rdata;
  logic load_we = 1'b0;
  logic [15:0] load_data = 16'h0;
  logic an_done = 1'b0;
  logic man_pin = 1'b0;
  logic dfc_pin = 1'b0;
  logic pol_pin = 1'b0;
  logic spd_pin = 1'b1;
  logic dup_pin = 1'b0;
  logic [15:0] adv_word;
  logic [15:0] lp_word;
  logic straps_valid;
  logic [15:0] got;
  int n_errors = 0;
  int tests_run = 0;

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  vpa_regs vpa_regs_i (
    .SYS_CLK(clk), .RST(rst), .CE(ce), .CSR_RE(csr_re), .CSR_WE(csr_we), .CSR_ADDR(csr_addr),
    .CSR_WDATA(csr_wdata), .CSR_RDATA(csr_rdata), .MIIM_RE(miim_re), .MIIM_WE(miim_we),
    .MIIM_IDX(miim_idx), .MIIM_WDATA(miim_wdata), .MIIM_RDATA(miim_rdata), .LOAD_WE(load_we),
    .LOAD_DATA(load_data), .AN_DONE(an_done), .MANUAL_FLOW_CTRL_CFG_PIN(man_pin),
    .DUPLEX_FLOW_CTRL_CFG_PIN(dfc_pin), .DUPLEX_POL_CFG_PIN(pol_pin), .SPEED_CFG_PIN(spd_pin),
    .PORT_ZERO_DUPLEX_PIN(dup_pin), .ADV_WORD(adv_word), .LP_WORD(lp_word), .STRAPS_VALID(straps_valid)
  );

  vpa_host_model vpa_host_model_i (
    .clk(clk), .re(miim_re), .we(miim_we), .idx(miim_idx), .wdata(miim_wdata), .rdata(miim_rdata)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Closing report
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic csr_wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    csr_we <= 1'b1;
    csr_addr <= a;
    csr_wdata <= d;
    @(posedge clk);
    csr_we <= 1'b0;
    csr_wdata <= ~d;
  endtask

  task automatic csr_chk(input logic [8:0] a, input logic [31:0] e, input string what);
    @(posedge clk);
    csr_re <= 1'b1;
    csr_addr <= a;
    @(posedge clk);
    csr_re <= 1'b0;
    #1;
    chk(csr_rdata, e, what);
  endtask

  // Reset with given straps, then wait a bounded time for the strap latch
  task automatic do_reset(input logic man, input logic dfc, input logic spd);
    int k;
    @(posedge clk);
    rst <= 1'b1;
    man_pin <= man;
    dfc_pin <= dfc;
    spd_pin <= spd;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    k = 0;
    while (straps_valid !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (straps_valid !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: straps never latched", $time);
      end_sim();
    end
  endtask

  task automatic pulse_an();
    @(posedge clk);
    an_done <= 1'b1;
    @(posedge clk);
    an_done <= 1'b0;
  endtask

  // All four advertised pause settings, resolved and then frozen
  task automatic pause_sweep(input logic dfc, input logic [3:0] abil);
    logic [1:0] p;
    logic [1:0] e;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      p = i[1:0];
      case (p)
        2'b00: e = 2'b00;
        2'b01: e = 2'b01;
        2'b10: e = 2'b11;
        default: e = dfc ? 2'b11 : 2'b10;
      endcase
      vpa_host_model_i.mii_wr(VPA_ADV_IDX, {4'h0, p, 10'h1e1});
      pulse_an();
      d = {2'b01, 2'b00, e, 1'b0, abil, 5'h01};
      vpa_host_model_i.mii_rd(VPA_LP_IDX, got);
      chk({16'h0, got}, {16'h0, d}, "partner pause");
      vpa_host_model_i.mii_wr(VPA_ADV_IDX, {4'h0, ~p, 10'h1e1});
      csr_chk(VPA_LP_OFS, {16'h0, d}, "partner pause frozen");
    end
    $display("test pause sweep done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'b0, 1'b0, 1'b1);
    csr_chk(VPA_ADV_OFS, 32'h0000_0de1, "advertise default");
    csr_chk(VPA_LP_OFS, 32'h0000_4101, "partner default");
    $display("test reset values done");
    csr_wr(VPA_ADV_OFS, 32'hffff_ffe1);
    csr_chk(VPA_ADV_OFS, 32'h0000_0de1, "fixed bits");
    csr_wr(VPA_LP_OFS, 32'hffff_ffff);
    csr_chk(VPA_LP_OFS, 32'h0000_4101, "partner write");
    csr_chk(9'h1d8, 32'h0, "unmapped read");
    @(posedge clk);
    ce <= 1'b0;
    csr_wr(VPA_ADV_OFS, 32'h0000_0001);
    ce <= 1'b1;
    csr_chk(VPA_ADV_OFS, 32'h0000_0de1, "write with clock enable low");
    $display("test access kinds done");
    @(posedge clk);
    load_we <= 1'b1;
    load_data <= 16'hf3a5;
    @(posedge clk);
    load_we <= 1'b0;
    @(posedge clk);
    #1;
    chk({16'h0, adv_word}, 32'h0000_01a5, "loader image");
    $display("test loader done");
    @(posedge clk);
    dup_pin <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({28'h0, lp_word[8:5]}, 32'h4, "partner half duplex");
    @(posedge clk);
    dup_pin <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({28'h0, lp_word[8:5]}, 32'h8, "partner full duplex");
    $display("test duplex pin done");
    pause_sweep(1'b0, 4'h8);
    do_reset(1'b1, 1'b1, 1'b0);
    @(posedge clk);
    dfc_pin <= 1'b0;
    csr_chk(VPA_ADV_OFS, 32'h0000_01e1, "advertise manual strap");
    vpa_host_model_i.mii_rd(VPA_LP_IDX, got);
    chk({16'h0, got}, 32'h0000_4041, "partner 10 full");
    pause_sweep(1'b1, 4'h2);
    end_sim();
  end
endmodule
